// ==== core/aics_defs.svh ====
/*
  Offsets, reset values and widths of the input-configuration and
  channel-select control block.
  Assumes inclusion by bare name from the package and the top module.
*/
`ifndef AICS_DEFS_SVH
`define AICS_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define AICS_CTRL_ADDR 4'h0
`define AICS_STAT_ADDR 4'h4

// ----------------------------------------------------------------
// Reset values and widths
// ----------------------------------------------------------------
`define AICS_CTRL_RST 8'h00
`define AICS_COUNT_RST 8'h00
`define AICS_SYNC_RST 3'h7
`define AICS_READ_RST 32'h00000000
// Selection after reset: channel zero, negative side grounded
`define AICS_MUX_RST 10'h008
`define AICS_SHARED_INPUT 3'h7
`define AICS_LAST_SEVEN 3'h6

`endif

// ==== core/aics_pkg.sv ====
/*
  Types of the input-configuration and channel-select control block.
  Assumes the constants header sits in the include path.
*/
package aics_pkg;
  `include "aics_defs.svh"

  // Bus handshake state, one-hot
  typedef enum logic [1:0] {
    AICS_BUS_IDLE = 2'b01,
    AICS_BUS_ACK = 2'b10
  } aics_bus_e;

  // Input wiring, written as {input_config_hi, input_config_lo}
  typedef enum logic [1:0] {
    AICS_CFG_SINGLE = 2'b00,
    AICS_CFG_PSEUDO4 = 2'b01,
    AICS_CFG_DIFF = 2'b10,
    AICS_CFG_PSEUDO7 = 2'b11
  } aics_cfg_e;

  // Control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic range_double;
    logic program_list_bit;
    logic auto_order_bit;
    logic input_config_hi;
    logic input_config_lo;
    logic [2:0] channel_pick_field;
  } aics_ctrl_s;

  // Multiplexer selection handed to the analog side
  typedef struct packed {
    logic [2:0] positive_input;
    logic [2:0] negative_input;
    logic neg_gnd;
    logic span_double;
    logic diff_code;
    logic seq_hold;
  } aics_mux_s;
endpackage

// ==== core/aics_top.sv ====
/*
  Control logic of an eight-input converter: input wiring choice and
  channel selection for the non-sequenced mode, behind an Avalon-MM slave.
  Assumes one 200 MHz clock, synchronous active-high reset, and an
  asynchronous active-low conversion start pin.
*/
// Behaviour
// RQ1 - Both configuration bits zero: eight single-ended channels.
// RQ2 - Low zero, high one: four fully differential pairs.
// RQ3 - Low one, high zero: four pseudo-differential pairs, negative carries offset.
// RQ4 - Both one: seven inputs measured against the eighth input.
// RQ5 - Input span programmable as one or two times reference.
// RQ6 - Sequencing and list bits zero: convert any host-chosen channel or pair.
// RQ7 - Host writes the channel field before the conversion it wants.
// RQ8 - No automatic advance; each write sets the following conversion.
// RQ9 - Differential difference from minus to plus reference spans all codes.
// RQ10 - Range bit zero gives single span, one gives double span.
// RQ11 - Single-ended: negative converter side tied to analog ground.
// RQ12 - Pair configurations: channel field selects a pair.
`timescale 1ns/1ps
`include "aics_defs.svh"
module aics_top
  import aics_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic conv_start_n,
  output aics_pkg::aics_mux_s mux_sel,
  output logic conv_fire
);
  import aics_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    aics_bus_e bus;
    logic waitrequest;
    logic [31:0] readdata;
    aics_ctrl_s ctrl;
    aics_mux_s mux;
    logic fire;
    logic [2:0] sync;
    logic [7:0] count;
  } aics_state_s;

  aics_state_s q;
  aics_state_s next_q;
  logic start_edge;
  logic bus_done;

  // Route the control word to the multiplexer for one conversion
  function automatic aics_mux_s aics_route(input aics_ctrl_s c, input aics_mux_s prev);
    aics_mux_s m;
    aics_cfg_e cfg;
    m = prev;
    cfg = aics_cfg_e'({c.input_config_hi, c.input_config_lo});
    // RQ6 selection only in non-sequenced mode
    if (c.auto_order_bit || c.program_list_bit) begin
      m.seq_hold = 1'b1;
    end else begin
      m.seq_hold = 1'b0;
      // RQ5 span follows range bit
      // RQ10 zero single, one double
      m.span_double = c.range_double;
      case (cfg)
        // RQ1 single-ended channel
        // RQ11 negative side to ground
        AICS_CFG_SINGLE: begin
          m.positive_input = c.channel_pick_field;
          m.negative_input = 3'h0;
          m.neg_gnd = 1'b1;
          m.diff_code = 1'b0;
        end
        // RQ2 fully differential pair
        // RQ12 field picks a pair
        // RQ9 difference spans all codes
        AICS_CFG_DIFF: begin
          m.positive_input = {c.channel_pick_field[1:0], 1'b0};
          m.negative_input = {c.channel_pick_field[1:0], 1'b1};
          m.neg_gnd = 1'b0;
          m.diff_code = 1'b1;
        end
        // RQ3 pseudo pair, offset on negative
        AICS_CFG_PSEUDO4: begin
          m.positive_input = {c.channel_pick_field[1:0], 1'b0};
          m.negative_input = {c.channel_pick_field[1:0], 1'b1};
          m.neg_gnd = 1'b0;
          m.diff_code = 1'b0;
        end
        // RQ4 seven against shared input
        AICS_CFG_PSEUDO7: begin
          // The shared input cannot be its own positive side, so seven clamps to six
          m.positive_input = (c.channel_pick_field == `AICS_SHARED_INPUT) ? `AICS_LAST_SEVEN
                                                                         : c.channel_pick_field;
          m.negative_input = `AICS_SHARED_INPUT;
          m.neg_gnd = 1'b0;
          m.diff_code = 1'b0;
        end
        default: begin
          m = prev;
        end
      endcase
    end
    return m;
  endfunction

  // Byte lane zero carries the whole control word
  function automatic logic aics_lane0(input logic [3:0] be);
    return be[0];
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Falling edge of the start pin, seen only past the second flop
  assign start_edge = q.sync[2] & ~q.sync[1];
  assign bus_done = (avs_read | avs_write) & ~q.waitrequest;

  always_comb begin
    next_q = q;
    next_q.fire = 1'b0;
    next_q.sync = {q.sync[1:0], conv_start_n};
    // One wait cycle per access keeps the read path a plain flop
    case (q.bus)
      AICS_BUS_IDLE: begin
        if (avs_read || avs_write) begin
          next_q.bus = AICS_BUS_ACK;
          next_q.waitrequest = 1'b0;
          case (avs_address)
            `AICS_CTRL_ADDR: next_q.readdata = {24'h000000, q.ctrl};
            `AICS_STAT_ADDR: next_q.readdata = {8'h00, q.count, 6'h00, q.mux};
            default: next_q.readdata = 32'h00000000;
          endcase
        end
      end
      AICS_BUS_ACK: begin
        next_q.bus = AICS_BUS_IDLE;
        next_q.waitrequest = 1'b1;
      end
      default: begin
        next_q.bus = AICS_BUS_IDLE;
        next_q.waitrequest = 1'b1;
      end
    endcase
    // RQ7 host write sets the field before the conversion
    if (bus_done && avs_write && avs_address == `AICS_CTRL_ADDR && aics_lane0(avs_byteenable)) begin
      next_q.ctrl = aics_ctrl_s'(avs_writedata[7:0]);
    end
    // RQ8 selection changes only at a start, from the word stored before that cycle
    if (start_edge) begin
      next_q.mux = aics_route(q.ctrl, q.mux);
      next_q.fire = 1'b1;
      next_q.count = q.count + 8'h01;
    end
  end

  // Register the whole state
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q.bus <= AICS_BUS_IDLE;
      q.waitrequest <= 1'b1;
      q.readdata <= `AICS_READ_RST;
      q.ctrl <= aics_ctrl_s'(`AICS_CTRL_RST);
      q.mux <= aics_mux_s'(`AICS_MUX_RST);
      q.fire <= 1'b0;
      q.sync <= `AICS_SYNC_RST;
      q.count <= `AICS_COUNT_RST;
    end else begin
      q <= next_q;
    end
  end

  assign avs_readdata = q.readdata;
  assign avs_waitrequest = q.waitrequest;
  assign mux_sel = q.mux;
  assign conv_fire = q.fire;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic trad;
  assign trad = ~q.ctrl.auto_order_bit & ~q.ctrl.program_list_bit;

  sequence s_ctrl_write;
    avs_write && !q.waitrequest && avs_address == `AICS_CTRL_ADDR && avs_byteenable[0];
  endsequence
  sequence s_start(logic [1:0] cfg);
    start_edge && trad && {q.ctrl.input_config_hi, q.ctrl.input_config_lo} == cfg;
  endsequence

  a_single_ended: assert property (s_start(2'b00) |=> mux_sel.neg_gnd && // RQ1
    mux_sel.positive_input == $past(q.ctrl.channel_pick_field)) else $error("single-ended route wrong");
  a_diff_pair: assert property (s_start(2'b10) |=> !mux_sel.neg_gnd && mux_sel.diff_code && // RQ2
    mux_sel.negative_input == mux_sel.positive_input + 3'h1) else $error("differential pair wrong");
  a_pseudo_pair: assert property (s_start(2'b01) |=> !mux_sel.diff_code && // RQ3
    mux_sel.positive_input == {$past(q.ctrl.channel_pick_field[1:0]), 1'b0}) else $error("pseudo pair wrong");
  a_pseudo_seven: assert property (s_start(2'b11) |=> mux_sel.negative_input == 3'h7 && // RQ4
    mux_sel.positive_input != 3'h7) else $error("seven-input route wrong");
  a_span_range: assert property (start_edge && trad |=> // RQ10
    mux_sel.span_double == $past(q.ctrl.range_double)) else $error("span does not follow range");
  a_gnd_single: assert property (mux_sel.neg_gnd && !mux_sel.seq_hold |-> // RQ11
    mux_sel.negative_input == 3'h0 && !mux_sel.diff_code) else $error("ground tie outside single mode");
  a_no_advance: assert property (!start_edge |=> $stable(mux_sel) && !conv_fire) // RQ8
    else $error("selection moved without a start");
  a_write_next: assert property (s_ctrl_write ##1 s_start(2'b00) |=> // RQ6
    mux_sel.positive_input == $past(avs_writedata[2:0], 2)) else $error("write not used by next start");
  a_pin_fire: assert property ($fell(q.sync[1]) |=> conv_fire ##1 !conv_fire) // RQ8
    else $error("start pin did not fire once");
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) // RQ7
    else $error("bus access not answered");
endmodule

// ==== dv/aics_host.sv ====
/*
  Host processor model: an Avalon-MM master that writes and reads the
  control block. Assumes one clock; the bench calls access() in place.
*/
`timescale 1ns/1ps
module aics_host (
  input wire logic sys_clk,
  output logic [3:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  // Bus idle at time zero
  initial begin
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
  end

  task automatic access(input logic rd, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
                        output logic [31:0] q);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= rd;
    avs_write <= !rd;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Stale data is inverted so it can never pass for a fresh write
    avs_writedata <= ~d;
  endtask
endmodule

// ==== dv/aics_top_tb.sv ====
/*
  Self-checking bench: host model drives the bus, the bench drives the
  start pin and queues the expected selection. Assumes the 200 MHz clock.
*/
`timescale 1ns/1ps
module aics_top_tb;
  import aics_pkg::*;
  logic sys_clk, rst, conv_start_n, avs_read, avs_write, avs_waitrequest, conv_fire;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [7:0] ctl, c;
  aics_mux_s mux_sel, last;
  aics_mux_s exp_q[$];
  int errors, checks, cycles, starts;

  aics_top i_dut (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .conv_start_n(conv_start_n),
    .mux_sel(mux_sel), .conv_fire(conv_fire));
  aics_host i_host (.sys_clk(sys_clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  function automatic aics_mux_s route(input logic [7:0] k);
    aics_mux_s m;
    m = last;
    m.seq_hold = 1'b1;
    if (k[6] | k[5]) begin
      return m;
    end
    m = '0;
    m.span_double = k[7];
    case (k[4:3])
      2'b00: begin
        m.positive_input = k[2:0];
        m.neg_gnd = 1'b1;
      end
      2'b11: begin
        m.positive_input = (k[2:0] == 3'h7) ? 3'h6 : k[2:0];
        m.negative_input = 3'h7;
      end
      default: begin
        m.positive_input = {k[1:0], 1'b0};
        m.negative_input = {k[1:0], 1'b1};
        m.diff_code = (k[4:3] == 2'b10);
      end
    endcase
    return m;
  endfunction

  task automatic wr(input logic [3:0] a, input logic [7:0] k, input logic [3:0] be);
    i_host.access(1'b0, a, {24'($urandom), k}, be, q);
    if (a == 4'h0 && be[0]) begin
      ctl = k;
    end
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
    i_host.access(1'b1, a, 32'h0, 4'hf, q);
    check(nm, q, e);
  endtask

  // Start pulse held three cycles, then high long enough to re-arm
  task automatic fire_start;
    last = route(ctl);
    exp_q.push_back(last);
    starts++;
    conv_start_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    conv_start_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
  endtask

  // Start taken one cycle after a write completes uses the new word;
  // taken in the same cycle as the write, it still uses the old word
  task automatic race_start(input logic [7:0] k, input logic same);
    last = route(same ? ctl : k);
    exp_q.push_back(last);
    starts++;
    fork
      wr(4'h0, k, 4'h1);
      begin
        if (!same) begin
          @(posedge sys_clk);
        end
        conv_start_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        conv_start_n <= 1'b1;
      end
    join
    repeat (6) @(posedge sys_clk);
  endtask

  // Every start must match the oldest queued selection
  always @(negedge sys_clk) begin
    if (conv_fire === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("spurious fire", 32'h1, 32'h0);
      end else begin
        check("mux_sel", {22'h0, mux_sel}, {22'h0, exp_q.pop_front()});
      end
    end
  end

  // Hang guard, far above the expected run length
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      print_verdict;
    end
  end

  initial begin
    rst = 1'b1;
    conv_start_n = 1'b1;
    ctl = 8'h00;
    last = 10'h008;
    void'($urandom(40676));
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rd(4'h0, 32'h0, "ctrl reset");
    rd(4'h4, 32'h8, "status reset");
    // All four wirings, both spans, random channels
    for (int i = 0; i < 32; i++) begin
      c = 8'($urandom);
      c[6:5] = 2'b00;
      c[4:3] = i[1:0];
      c[7] = i[2];
      wr(4'h0, c, 4'h1);
      fire_start;
    end
    wr(4'h0, 8'h1f, 4'h1);
    fire_start;
    // Last of two writes wins; no advance on a repeated start
    wr(4'h0, 8'h02, 4'h1);
    wr(4'h0, 8'h15, 4'h1);
    fire_start;
    fire_start;
    // Write and start close together: one cycle apart, then in the same cycle
    race_start(8'h05, 1'b0);
    race_start(8'h12, 1'b1);
    fire_start;
    // Writes that must be ignored
    wr(4'h0, 8'h0b, 4'h0);
    wr(4'h8, 8'h14, 4'h1);
    wr(4'h4, 8'h00, 4'h1);
    fire_start;
    rd(4'h8, 32'h0, "unmapped");
    wr(4'h0, 8'h21, 4'h1);
    fire_start;
    wr(4'h0, 8'hc7, 4'h1);
    fire_start;
    rd(4'h0, {24'h0, ctl}, "ctrl readback");
    rd(4'h4, {8'h0, 8'(starts), 6'h0, last}, "status");
    check("pending", 32'(exp_q.size()), 32'h0);
    print_verdict;
  end
endmodule
